//--- hdl/usb_irq_ep_pkg.sv
// constants and carrier types for the interrupt enable and endpoint index bank
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register port
package usb_irq_ep_pkg;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0]  IRQ_ENABLE_OFFSET      = 8'h14;
   localparam logic [7:0]  ENDPOINT_SELECT_OFFSET = 8'h2c;
   localparam logic [7:0]  MODE_CONTROL_OFFSET    = 8'h30;
   localparam logic [7:0]  GATED_STATUS_OFFSET    = 8'h34;

   // ==========================================================
   // interrupt enable fields
   localparam int          IRQ_SOURCE_COUNT       = 26;
   localparam int          ENDPOINT_EN_LSB        = 12;
   localparam int          CONTROL_IN_BIT         = 11;
   localparam int          CONTROL_OUT_BIT        = 10;
   localparam int          RESERVED_IRQ_BIT       = 9;
   localparam int          SETUP_RECEIVED_BIT     = 8;
   localparam int          SUPPLY_SENSE_BIT       = 7;
   localparam int          DMA_REASON_BIT         = 6;
   localparam int          SPEED_CHANGE_BIT       = 5;
   localparam int          RESUME_BIT             = 4;
   localparam int          SUSPEND_BIT            = 3;
   localparam int          PSEUDO_FRAME_BIT       = 2;
   localparam int          FRAME_START_BIT        = 1;
   localparam int          BUS_RESET_BIT          = 0;
   localparam logic [31:0] IRQ_ENABLE_IMPL_MASK   = 32'h03ff_fdff;
   localparam logic [31:0] IRQ_ENABLE_RESET       = 32'h0000_0000;
   localparam logic [31:0] IRQ_ENABLE_BUS_RESET   = 32'h0000_0001;

   // ==========================================================
   // endpoint index fields
   localparam int          DIRECTION_BIT          = 0;
   localparam int          ENDPOINT_NUMBER_LSB    = 1;
   localparam int          ENDPOINT_NUMBER_WIDTH  = 4;
   localparam int          SETUP_SELECT_BIT       = 5;
   localparam logic [7:0]  ENDPOINT_SELECT_MASK   = 8'h3f;
   localparam logic [7:0]  ENDPOINT_SELECT_RESET  = 8'h20;

   // ==========================================================
   // mode control fields
   localparam int          GLOBAL_IRQ_BIT         = 0;
   localparam logic        GLOBAL_IRQ_RESET       = 1'b0;

   // ==========================================================
   // index-to-data-port settling times
   localparam int          CLK_PERIOD_NS          = 10;
   localparam int          READ_SETTLE_NS         = 190;
   localparam int          WRITE_SETTLE_NS        = 100;
   localparam int          READ_SETTLE_CYCLES     = (READ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WRITE_SETTLE_CYCLES    = (WRITE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SETTLE_COUNT_WIDTH     = 5;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      BUF_SETUP       = 3'b000,
      BUF_CONTROL_OUT = 3'b001,
      BUF_CONTROL_IN  = 3'b010,
      BUF_DATA_OUT    = 3'b011,
      BUF_DATA_IN     = 3'b100,
      BUF_INVALID     = 3'b101
   } buffer_sel_e;

   typedef struct packed {
      logic                             setup_buffer_select;
      logic [ENDPOINT_NUMBER_WIDTH-1:0] endpoint_number;
      logic                             direction;
   } endpoint_select_s;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avmm_req_s;

endpackage

//--- hdl/buffer_decoder.sv
// decodes the endpoint index into the buffer it addresses
// assumes a registered endpoint index from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module buffer_decoder #(
   parameter int ENDPOINT_COUNT = 8
) (
   input  wire usb_irq_ep_pkg::endpoint_select_s i_index,
   output var  usb_irq_ep_pkg::buffer_sel_e      o_buffer
);

   // ==========================================================
   // elaboration check
   if (ENDPOINT_COUNT < 1 || ENDPOINT_COUNT > 16) begin : g_bad_count
      $error("endpoint count must lie in 1 to 16");
   end

   // ==========================================================
   // decode
   always_comb begin
      o_buffer = usb_irq_ep_pkg::BUF_INVALID;
      if (i_index.setup_buffer_select) begin
         // set-up buffer only exists as endpoint 0, out direction
         if (i_index.endpoint_number == 4'h0 && !i_index.direction) begin
            o_buffer = usb_irq_ep_pkg::BUF_SETUP;
         end
      end else if (i_index.endpoint_number == 4'h0) begin
         o_buffer = i_index.direction ? usb_irq_ep_pkg::BUF_CONTROL_IN
                                      : usb_irq_ep_pkg::BUF_CONTROL_OUT;
      end else if (32'(i_index.endpoint_number) < ENDPOINT_COUNT) begin
         o_buffer = i_index.direction ? usb_irq_ep_pkg::BUF_DATA_IN
                                      : usb_irq_ep_pkg::BUF_DATA_OUT;
      end
   end

endmodule // buffer_decoder

`default_nettype wire

//--- hdl/usb_irq_enable_and_ep_index.sv
// interrupt enable and endpoint index register bank behind an Avalon-MM slave
// assumes event, bus-reset and dma endpoint inputs come from logic on i_clk
//
// Overview of operation
// - bits 25..12 hold rx and tx enables for endpoints 1 to 7
// - bit 11 control in enable, bit 10 control out enable, bit 9 reserved
// - bit 8 enables the set-up received interrupt
// - bit 7 enables the supply sense interrupt
// - bit 6 enables the dma reason change interrupt
// - bit 5 enables the speed change interrupt
// - bit 4 enables resume, bit 3 enables suspend interrupts
// - bit 2 enables pseudo frame start, bit 1 real frame start
// - bit 0 enables the bus reset interrupt
// - enables reset to zero; bus reset clears all but forces bit 0
// - endpoint index picks the target of the indexed registers
// - endpoint number is a 4-bit field in index bits 4..1
// - index bit 0: 0 addresses the out buffer, 1 the in buffer
// - index bit 5 picks endpoint 0 set-up buffer; zero for others
// - set-up, control out and control in all use endpoint 0
// - index resets to set-up select one; bus reset keeps that bit only
// - a global enable bit gates every interrupt source
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module usb_irq_enable_and_ep_index #(
   parameter int ENDPOINT_COUNT = 8
) (
   input  wire logic                                      i_clk,
   input  wire logic                                      i_rst_n,
   input  wire usb_irq_ep_pkg::avmm_req_s                 i_avmm,
   input  wire logic                                      i_usb_bus_reset,
   input  wire logic [usb_irq_ep_pkg::IRQ_SOURCE_COUNT-1:0] i_irq_events,
   input  wire logic [3:0]                                i_dma_endpoint_number,
   output logic [31:0]                                    o_avmm_readdata,
   output logic                                           o_avmm_waitrequest,
   output logic [31:0]                                    o_irq_enable,
   output logic                                           o_global_irq_enable,
   output logic [usb_irq_ep_pkg::IRQ_SOURCE_COUNT-1:0]    o_gated_events,
   output usb_irq_ep_pkg::endpoint_select_s               o_endpoint_select,
   output usb_irq_ep_pkg::buffer_sel_e                    o_buffer_select,
   output logic                                           o_data_read_settled,
   output logic                                           o_data_write_settled,
   output logic                                           o_dma_index_clash
);

   localparam int SW = usb_irq_ep_pkg::SETTLE_COUNT_WIDTH;
   localparam int NS = usb_irq_ep_pkg::IRQ_SOURCE_COUNT;

   // ==========================================================
   // elaboration checks
   if (usb_irq_ep_pkg::READ_SETTLE_CYCLES >= (1 << SW) ||
       usb_irq_ep_pkg::WRITE_SETTLE_CYCLES >= (1 << SW)) begin : g_bad_settle
      $error("settle counter too narrow for the settle times");
   end
   if (ENDPOINT_COUNT != 8) begin : g_bad_endpoints
      $error("enable layout serves exactly eight endpoints");
   end

   // ==========================================================
   // state
   typedef enum logic [0:0] {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_e;

   typedef struct packed {
      bus_state_e                       bus;
      logic                             waitrequest;
      logic [31:0]                      readdata;
      logic [31:0]                      irq_enable;
      logic                             global_irq;
      usb_irq_ep_pkg::endpoint_select_s index;
      usb_irq_ep_pkg::buffer_sel_e      buffer;
      logic [NS-1:0]                    gated;
      logic [SW-1:0]                    read_settle;
      logic [SW-1:0]                    write_settle;
      logic                             read_settled;
      logic                             write_settled;
      logic                             clash;
   } state_s;

   localparam state_s STATE_RESET = '{
      bus:           BUS_IDLE,
      waitrequest:   1'b1,
      readdata:      32'h0000_0000,
      irq_enable:    usb_irq_ep_pkg::IRQ_ENABLE_RESET,
      global_irq:    usb_irq_ep_pkg::GLOBAL_IRQ_RESET,
      index:         usb_irq_ep_pkg::endpoint_select_s'(usb_irq_ep_pkg::ENDPOINT_SELECT_RESET[5:0]),
      buffer:        usb_irq_ep_pkg::BUF_SETUP,
      gated:         '0,
      read_settle:   '0,
      write_settle:  '0,
      read_settled:  1'b1,
      write_settled: 1'b1,
      clash:         1'b0
   };

   state_s                      state_reg;
   state_s                      state_next;
   usb_irq_ep_pkg::buffer_sel_e decoded_buffer;
   logic [31:0]                 read_value;
   logic [31:0]                 merged_word;
   logic                        index_written;

   // ==========================================================
   // buffer decode of the held index
   buffer_decoder #(
      .ENDPOINT_COUNT (ENDPOINT_COUNT)
   ) u_buffer_decoder (
      .i_index  (state_reg.index),
      .o_buffer (decoded_buffer)
   );

   // ==========================================================
   // read mux; unmapped offsets read zero
   always_comb begin
      read_value = 32'h0000_0000;
      unique case (i_avmm.address)
         usb_irq_ep_pkg::IRQ_ENABLE_OFFSET: begin
            read_value = state_reg.irq_enable & usb_irq_ep_pkg::IRQ_ENABLE_IMPL_MASK;
         end
         usb_irq_ep_pkg::ENDPOINT_SELECT_OFFSET: begin
            read_value = {26'h0, state_reg.index};
         end
         usb_irq_ep_pkg::MODE_CONTROL_OFFSET: begin
            read_value[usb_irq_ep_pkg::GLOBAL_IRQ_BIT] = state_reg.global_irq;
         end
         usb_irq_ep_pkg::GATED_STATUS_OFFSET: begin
            read_value = {6'h0, state_reg.gated};
         end
         default: begin
            read_value = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // byte-lane merge of write data over the current enable word
   always_comb begin
      merged_word = state_reg.irq_enable;
      for (int b = 0; b < 4; b++) begin
         if (i_avmm.byteenable[b]) begin
            merged_word[b*8 +: 8] = i_avmm.writedata[b*8 +: 8];
         end
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      state_next    = state_reg;
      index_written = 1'b0;

      // two-cycle answer: waitrequest drops one cycle after the request
      unique case (state_reg.bus)
         BUS_IDLE: begin
            if (i_avmm.read || i_avmm.write) begin
               state_next.bus         = BUS_ANSWER;
               state_next.waitrequest = 1'b0;
               state_next.readdata    = i_avmm.read ? read_value : 32'h0000_0000;
            end
         end
         BUS_ANSWER: begin
            state_next.bus         = BUS_IDLE;
            state_next.waitrequest = 1'b1;
            // write takes effect at the edge where waitrequest is seen low
            if (i_avmm.write) begin
               unique case (i_avmm.address)
                  usb_irq_ep_pkg::IRQ_ENABLE_OFFSET: begin
                     // bit 9 and 31..26 never store
                     state_next.irq_enable = merged_word & usb_irq_ep_pkg::IRQ_ENABLE_IMPL_MASK;
                  end
                  usb_irq_ep_pkg::ENDPOINT_SELECT_OFFSET: begin
                     if (i_avmm.byteenable[0]) begin
                        state_next.index = usb_irq_ep_pkg::endpoint_select_s'(
                           i_avmm.writedata[5:0] & usb_irq_ep_pkg::ENDPOINT_SELECT_MASK[5:0]);
                        index_written    = 1'b1;
                     end
                  end
                  usb_irq_ep_pkg::MODE_CONTROL_OFFSET: begin
                     if (i_avmm.byteenable[0]) begin
                        state_next.global_irq = i_avmm.writedata[usb_irq_ep_pkg::GLOBAL_IRQ_BIT];
                     end
                  end
                  default: begin
                     state_next.global_irq = state_reg.global_irq;
                  end
               endcase
            end
         end
      endcase

      // usb bus reset wins over a software write in the same cycle
      if (i_usb_bus_reset) begin
         state_next.irq_enable                = usb_irq_ep_pkg::IRQ_ENABLE_BUS_RESET;
         state_next.index.endpoint_number     = '0;
         state_next.index.direction           = 1'b0;
         index_written                        = 1'b1;
      end

      // settle timers: index change restarts the data-port wait
      if (index_written) begin
         state_next.read_settle   = SW'(usb_irq_ep_pkg::READ_SETTLE_CYCLES);
         state_next.write_settle  = SW'(usb_irq_ep_pkg::WRITE_SETTLE_CYCLES);
         state_next.read_settled  = 1'b0;
         state_next.write_settled = 1'b0;
      end else begin
         if (state_reg.read_settle != '0) begin
            state_next.read_settle = state_reg.read_settle - SW'(1);
         end
         if (state_reg.write_settle != '0) begin
            state_next.write_settle = state_reg.write_settle - SW'(1);
         end
         state_next.read_settled  = (state_reg.read_settle <= SW'(1));
         state_next.write_settled = (state_reg.write_settle <= SW'(1));
      end

      // indexed registers follow this decode
      state_next.buffer = decoded_buffer;

      // each source passes its own enable and the global enable
      state_next.gated = i_irq_events & state_reg.irq_enable[NS-1:0]
                       & {NS{state_reg.global_irq}};
      state_next.gated[usb_irq_ep_pkg::RESERVED_IRQ_BIT] = 1'b0;

      // flag a shared endpoint number with the dma channel
      state_next.clash = (state_reg.index.endpoint_number == i_dma_endpoint_number);
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign o_avmm_readdata      = state_reg.readdata;
   assign o_avmm_waitrequest   = state_reg.waitrequest;
   assign o_irq_enable         = state_reg.irq_enable;
   assign o_global_irq_enable  = state_reg.global_irq;
   assign o_gated_events       = state_reg.gated;
   assign o_endpoint_select    = state_reg.index;
   assign o_buffer_select      = state_reg.buffer;
   assign o_data_read_settled  = state_reg.read_settled;
   assign o_data_write_settled = state_reg.write_settled;
   assign o_dma_index_clash    = state_reg.clash;

endmodule // usb_irq_enable_and_ep_index

`default_nettype wire

//--- verif/usb_irq_ep_props.sv
// concurrent checks for the enable and index register bank
// assumes it is bound into usb_irq_enable_and_ep_index
`timescale 1ns/10ps
`default_nettype none
module usb_irq_ep_props (
   input wire logic                             i_clk,
   input wire logic                             i_rst_n,
   input wire usb_irq_ep_pkg::avmm_req_s        i_avmm,
   input wire logic                             i_usb_bus_reset,
   input wire logic [25:0]                      i_irq_events,
   input wire logic [3:0]                       i_dma_endpoint_number,
   input wire logic                             o_avmm_waitrequest,
   input wire logic [31:0]                      o_irq_enable,
   input wire logic                             o_global_irq_enable,
   input wire logic [25:0]                      o_gated_events,
   input wire usb_irq_ep_pkg::endpoint_select_s o_endpoint_select,
   input wire usb_irq_ep_pkg::buffer_sel_e      o_buffer_select,
   input wire logic                             o_data_read_settled,
   input wire logic                             o_data_write_settled,
   input wire logic                             o_dma_index_clash
);
   // ==========================================
   // helpers
   logic        wr_ok;
   logic        clash_now;
   logic [25:0] gate_now;
   // bus reset wins over a same-edge write
   assign wr_ok = i_avmm.write && !o_avmm_waitrequest && !i_usb_bus_reset;
   assign clash_now = o_endpoint_select.endpoint_number == i_dma_endpoint_number;
   assign gate_now = i_irq_events & o_irq_enable[25:0] & {26{o_global_irq_enable}};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_reserved_zero: assert property (o_irq_enable[31:26] == 6'h00 && !o_irq_enable[9])
      else $error("reserved enable bit set");
   a_bus_reset_irq: assert property (i_usb_bus_reset |=> o_irq_enable == 32'h0000_0001)
      else $error("bus reset enables wrong");
   a_bus_reset_index: assert property (i_usb_bus_reset |=>
      o_endpoint_select[4:0] == 5'h00 && $stable(o_endpoint_select[5])) else $error("bus reset index wrong");
   a_irq_write: assert property (wr_ok && i_avmm.address == 8'h14 && i_avmm.byteenable == 4'hf |=>
      o_irq_enable == ($past(i_avmm.writedata) & 32'h03ff_fdff)) else $error("enable write lost");
   a_index_write: assert property (wr_ok && i_avmm.address == 8'h2c && i_avmm.byteenable[0] |=>
      o_endpoint_select == $past(i_avmm.writedata[5:0])) else $error("index write lost");
   a_gated_path: assert property ($past(i_rst_n) |-> o_gated_events == $past(gate_now))
      else $error("gated events wrong");
   a_ep0_decode: assert property ($past(o_endpoint_select[5:1]) == 5'h00 |-> o_buffer_select ==
      ($past(o_endpoint_select[0]) ? usb_irq_ep_pkg::BUF_CONTROL_IN : usb_irq_ep_pkg::BUF_CONTROL_OUT))
      else $error("control buffer decode wrong");
   a_data_decode: assert property ($past(o_endpoint_select[5:4]) == 2'b00 &&
      $past(o_endpoint_select[3:1]) != 3'h0 |-> o_buffer_select ==
      ($past(o_endpoint_select[0]) ? usb_irq_ep_pkg::BUF_DATA_IN : usb_irq_ep_pkg::BUF_DATA_OUT))
      else $error("data buffer decode wrong");
   a_write_settle: assert property (wr_ok && i_avmm.address == 8'h2c |=> !o_data_write_settled [*8])
      else $error("settle flag early");
   // host keeps a gap of at least 20 cycles after an index write
   a_read_settle: assert property (wr_ok && i_avmm.address == 8'h2c && i_avmm.byteenable[0] |=>
      !o_data_read_settled [*8] ##1 !o_data_read_settled [*8] ##1 !o_data_read_settled [*3]
      ##1 o_data_read_settled) else $error("read settle flag wrong");
   a_clash_flag: assert property ($past(i_rst_n) |-> o_dma_index_clash == $past(clash_now))
      else $error("clash flag wrong");
endmodule // usb_irq_ep_props
bind usb_irq_enable_and_ep_index usb_irq_ep_props props_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avmm(i_avmm),
   .i_usb_bus_reset(i_usb_bus_reset), .i_irq_events(i_irq_events), .i_dma_endpoint_number(i_dma_endpoint_number),
   .o_avmm_waitrequest(o_avmm_waitrequest), .o_irq_enable(o_irq_enable), .o_global_irq_enable(o_global_irq_enable),
   .o_gated_events(o_gated_events), .o_endpoint_select(o_endpoint_select), .o_buffer_select(o_buffer_select),
   .o_data_read_settled(o_data_read_settled), .o_data_write_settled(o_data_write_settled),
   .o_dma_index_clash(o_dma_index_clash));
`default_nettype wire

//--- verif/host_cpu_model.sv
// host processor model, Avalon-MM master of the register port
// assumes the bank answers with waitrequest low
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
   input  wire logic                      i_clk,
   input  wire logic                      i_waitrequest,
   output var usb_irq_ep_pkg::avmm_req_s  o_avmm
);
   initial o_avmm = '{default: 1'b0};
   // call right after a rising edge; waits as long as the slave needs
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      o_avmm <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
      @(posedge i_clk);
      while (i_waitrequest !== 1'b0) @(posedge i_clk);
      // released strobes drop to zero; address, data and byte enables show the inverse, never a stale copy
      o_avmm <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d, byteenable: ~be};
      repeat ($urandom_range(3, 1)) @(posedge i_clk);
      if (w && a == 8'h2c) repeat (19) @(posedge i_clk);
   endtask
endmodule // host_cpu_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the enable and index bank
// assumes host_cpu_model as master and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic                             i_clk = 1'b0;
   logic                             i_rst_n = 1'b0;
   logic                             i_usb_bus_reset = 1'b0;
   logic [25:0]                      i_irq_events = '0;
   logic [3:0]                       i_dma_endpoint_number = 4'hf;
   logic [31:0]                      rdata, v, shadow;
   logic [3:0]                       be;
   logic                             waitreq;
   usb_irq_ep_pkg::avmm_req_s        avmm;
   usb_irq_ep_pkg::endpoint_select_s ep_sel;
   usb_irq_ep_pkg::buffer_sel_e      buf_sel;
   logic [31:0]                      exp_q[$];
   int                               err_total = 0;
   int                               checked = 0;
   logic [7:0]                       idx_val [8] = '{8'h20, 8'h00, 8'h01, 8'h02, 8'h0f, 8'h21, 8'hff, 8'h10};
   logic [2:0]                       idx_buf [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5};
   always #5 i_clk = ~i_clk;
   usb_irq_enable_and_ep_index usb_irq_enable_and_ep_index_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avmm(avmm),
      .i_usb_bus_reset(i_usb_bus_reset), .i_irq_events(i_irq_events), .i_dma_endpoint_number(i_dma_endpoint_number),
      .o_avmm_readdata(rdata), .o_avmm_waitrequest(waitreq), .o_irq_enable(), .o_global_irq_enable(),
      .o_gated_events(), .o_endpoint_select(ep_sel), .o_buffer_select(buf_sel), .o_data_read_settled(),
      .o_data_write_settled(), .o_dma_index_clash());
   host_cpu_model host_cpu_model_i (.i_clk(i_clk), .i_waitrequest(waitreq), .o_avmm(avmm));
   // ==========================================
   // compare and bus tasks
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_buf(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: buffer %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
      host_cpu_model_i.xfer(1'b1, a, d, b);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      host_cpu_model_i.xfer(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic do_reset();
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(8'h14, 32'h0);
      rd(8'h2c, 32'h20);
      rd(8'h30, 32'h0);
   endtask
   task automatic bus_rst();
      i_usb_bus_reset <= 1'b1;
      @(posedge i_clk);
      i_usb_bus_reset <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // read answers are matched against the oldest note
   always @(posedge i_clk) begin
      if (i_rst_n === 1'b1 && waitreq === 1'b0 && avmm.read === 1'b1) begin
         cmp_word(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
      end
   end
   // ==========================================
   // scenarios
   initial begin
      void'($urandom(27272));
      do_reset();
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h1 << i);
         rd(8'h14, (32'h1 << i) & 32'h03ff_fdff);
      end
      shadow = 32'h0;
      repeat (6) begin
         v = $urandom;
         be = 4'($urandom);
         wr(8'h14, v, be);
         for (int b = 0; b < 4; b++) if (be[b]) shadow[8*b +: 8] = v[8*b +: 8];
         shadow &= 32'h03ff_fdff;
         rd(8'h14, shadow);
      end
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08, 32'h0);
      rd(8'h14, shadow);
      foreach (idx_val[k]) begin
         wr(8'h2c, {24'h0, idx_val[k]});
         rd(8'h2c, {24'h0, idx_val[k] & 8'h3f});
         cmp_buf(buf_sel, idx_buf[k]);
      end
      wr(8'h14, 32'h03ff_fdff);
      for (int g = 0; g < 2; g++) begin
         wr(8'h30, 32'(g));
         rd(8'h30, 32'(g));
         repeat (4) begin
            v = $urandom;
            i_irq_events <= v[25:0];
            i_dma_endpoint_number <= ~ep_sel.endpoint_number;
            @(posedge i_clk);
            rd(8'h34, g ? (v & 32'h03ff_fdff) : 32'h0);
         end
      end
      wr(8'h2c, 32'h2b);
      bus_rst();
      rd(8'h14, 32'h1);
      rd(8'h2c, 32'h20);
      rd(8'h30, 32'h1);
      wr(8'h2c, 32'h0b);
      bus_rst();
      rd(8'h2c, 32'h0);
      do_reset();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
